/* File: sbm_pkg.sv */
// Purpose: shared constants and types for the bus mastership handshake
// Assumes: one system clock, all strobes active low
// Notes: none
package sbm_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned SBM_CLK_NS = 10;
  localparam logic [1:0] SBM_REQ_DROP_CYC = 2'h2;
  localparam logic [1:0] SBM_REL_WAIT_CYC = 2'h2;
  localparam logic [1:0] SBM_RELEASE_GAP_CYC = 2'h2;
  localparam logic [1:0] SBM_CNT_ZERO = 2'h0;
  localparam logic [1:0] SBM_CNT_ONE = 2'h1;

  // ----------------------------------------------------------------
  // states, gray coded along slave, wait, turn-on, master, drain
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SBM_SLAVE  = 3'h0,
    SBM_WAIT   = 3'h1,
    SBM_TURNON = 3'h3,
    SBM_MASTER = 3'h2,
    SBM_DRAIN  = 3'h6,
    SBM_RELEASE = 3'h7
  } sbm_state_t;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic work_ready;
    logic resources_ok;
    logic issue;
  } sbm_user_t;

  typedef struct packed {
    logic bus_grant_n;
    logic bus_release_n;
  } sbm_arb_in_t;

endpackage : sbm_pkg

/* File: sbm_delay2.sv */
// Purpose: two-stage registered delay of a level
// Assumes: synchronous active low reset
// Notes: resets to the given constant
`timescale 1ns/10ps
`default_nettype none
module sbm_delay2 #(
  parameter logic RST_VAL = 1'b1
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_d,
  output logic o_q1,
  output logic o_q2
);
  typedef struct packed {
    logic q1;
    logic q2;
  } sbm_dly_t;

  sbm_dly_t state_ff;
  sbm_dly_t nxt_state;

  always_comb begin
    nxt_state.q1 = i_d;
    nxt_state.q2 = state_ff.q1;
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      state_ff <= {RST_VAL, RST_VAL};
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign o_q1 = state_ff.q1;
  assign o_q2 = state_ff.q2;
endmodule : sbm_delay2
`default_nettype wire

/* File: sbm_arb_handshake.sv */
// Purpose: processor end of the shared bus mastership handshake
// Assumes: strobes sampled on the rising clock edge, inputs synchronous
// Notes: encodings of command and response fields are outside this block
//
// Contract
// - any reset leaves the bus in slave state, not driving lines
// - one dead cycle at each ownership change; lines ignored then
// - arbitration overlaps requests and responses
// - request raised only when work ready and resources available
// - request held until grant seen, dropped two cycles after grant
// - become master and drive two cycles after release seen
// - master keeps the bus until grant is seen negated
// - release pulse one cycle, at least two cycles after grant negated
// - issuing allowed in the two cycles after grant negation
// - issue only in master state, back to back allowed
`timescale 1ns/10ps
`default_nettype none
module sbm_arb_handshake
  import sbm_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire sbm_user_t i_user,
  input wire sbm_arb_in_t i_arb,
  output logic o_bus_request_n,
  output logic o_bus_release_n,
  output logic o_bus_drive_en,
  output logic o_issue_ok,
  output logic o_sample_ok,
  output logic o_is_master
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    sbm_state_t st;
    logic req_n;
    logic rel_n;
    logic drive;
    logic issue_ok;
    logic sample_ok;
    logic master;
    logic gnt_seen;
    logic [1:0] cnt;
  } sbm_core_t;

  sbm_core_t state_ff;
  sbm_core_t nxt_state;

  logic gnt_q1;
  logic gnt_q2;
  logic rel_q1;
  logic rel_q2;

  // grant and release delayed by two edges, registered sampling
  sbm_delay2 #(.RST_VAL(1'b1)) u_gnt_dly (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_d(i_arb.bus_grant_n),
    .o_q1(gnt_q1),
    .o_q2(gnt_q2)
  );

  sbm_delay2 #(.RST_VAL(1'b1)) u_rel_dly (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_d(i_arb.bus_release_n),
    .o_q1(rel_q1),
    .o_q2(rel_q2)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_state.rel_n = 1'b1;
    case (state_ff.st)
      SBM_SLAVE: begin
        nxt_state.drive = 1'b0;
        nxt_state.master = 1'b0;
        nxt_state.issue_ok = 1'b0;
        // parked grant may already be ours, but mastership needs release
        if (i_user.work_ready && i_user.resources_ok) begin
          nxt_state.req_n = 1'b0;
          nxt_state.gnt_seen = 1'b0;
          nxt_state.st = SBM_WAIT;
        end
        if (!i_arb.bus_release_n && !i_arb.bus_grant_n) begin
          nxt_state.st = SBM_TURNON;
          nxt_state.cnt = SBM_REL_WAIT_CYC - SBM_CNT_ONE;
          nxt_state.sample_ok = 1'b0;
        end
      end
      SBM_WAIT: begin
        // request is held regardless of the work vanishing
        if (!i_arb.bus_grant_n && !state_ff.gnt_seen) begin
          nxt_state.gnt_seen = 1'b1;
        end
        if (!i_arb.bus_release_n) begin
          nxt_state.st = SBM_TURNON;
          nxt_state.cnt = SBM_REL_WAIT_CYC - SBM_CNT_ONE;
          nxt_state.sample_ok = 1'b0;
        end
      end
      SBM_TURNON: begin
        // dead cycle is the first one here: nobody drives, lines ignored
        if (state_ff.cnt == SBM_CNT_ZERO) begin
          nxt_state.st = SBM_MASTER;
        end else begin
          nxt_state.cnt = state_ff.cnt - SBM_CNT_ONE;
          nxt_state.sample_ok = 1'b1;
          nxt_state.drive = 1'b1;
          nxt_state.master = 1'b1;
          nxt_state.issue_ok = 1'b1;
        end
      end
      SBM_MASTER: begin
        // issuing goes on while grant may be withdrawn
        nxt_state.issue_ok = 1'b1;
        if (gnt_q1) begin
          nxt_state.st = SBM_DRAIN;
          nxt_state.cnt = SBM_RELEASE_GAP_CYC - SBM_CNT_ONE;
        end
      end
      SBM_DRAIN: begin
        // issuing stays allowed; a busy issue postpones the release
        if (state_ff.cnt != SBM_CNT_ZERO) begin
          nxt_state.cnt = state_ff.cnt - SBM_CNT_ONE;
        end else if (!i_user.issue) begin
          nxt_state.rel_n = 1'b0;
          nxt_state.issue_ok = 1'b0;
          nxt_state.st = SBM_RELEASE;
        end
      end
      SBM_RELEASE: begin
        nxt_state.drive = 1'b0;
        nxt_state.master = 1'b0;
        nxt_state.issue_ok = 1'b0;
        nxt_state.sample_ok = 1'b0;
        nxt_state.st = SBM_SLAVE;
      end
      default: begin
        nxt_state.st = SBM_SLAVE;
      end
    endcase
    // request drops two cycles after grant was first observed
    if (state_ff.req_n == 1'b0 && !gnt_q2 && state_ff.gnt_seen) begin
      nxt_state.req_n = 1'b1;
    end
    if (state_ff.st == SBM_SLAVE && state_ff.drive == 1'b0 && state_ff.sample_ok == 1'b0) begin
      nxt_state.sample_ok = 1'b1;
    end
    if (state_ff.st == SBM_MASTER) begin
      nxt_state.sample_ok = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      state_ff.st <= SBM_SLAVE;
      state_ff.req_n <= 1'b1;
      state_ff.rel_n <= 1'b1;
      state_ff.drive <= 1'b0;
      state_ff.issue_ok <= 1'b0;
      state_ff.sample_ok <= 1'b1;
      state_ff.master <= 1'b0;
      state_ff.gnt_seen <= 1'b0;
      state_ff.cnt <= SBM_CNT_ZERO;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign o_bus_request_n = state_ff.req_n;
  assign o_bus_release_n = state_ff.rel_n;
  assign o_bus_drive_en = state_ff.drive;
  assign o_issue_ok = state_ff.issue_ok;
  assign o_sample_ok = state_ff.sample_ok;
  assign o_is_master = state_ff.master;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_reset_slave: assert property (@(posedge i_clk) !i_resetn |=> !o_bus_drive_en)
    else $error("bus driven after reset");
  a_master_two: assert property (@(posedge i_clk) disable iff (!i_resetn)
    ($fell(i_arb.bus_release_n) && o_bus_release_n && !i_arb.bus_grant_n && !o_is_master)
      |=> ##1 o_bus_drive_en)
    else $error("master not taken two cycles after release");
  a_rel_pulse: assert property (@(posedge i_clk) disable iff (!i_resetn)
    !o_bus_release_n |=> o_bus_release_n)
    else $error("release pulse longer than one cycle");
  a_rel_gap: assert property (@(posedge i_clk) disable iff (!i_resetn)
    $rose(i_arb.bus_grant_n) |=> o_bus_release_n [*2])
    else $error("release too soon after grant negated");
  a_keep_bus: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (o_is_master && !i_arb.bus_grant_n && !gnt_q1) |=> o_is_master)
    else $error("mastership dropped while granted");
  a_dead_cycle: assert property (@(posedge i_clk) disable iff (!i_resetn)
    !o_bus_release_n |=> !o_bus_drive_en && !o_sample_ok)
    else $error("no dead cycle after release");
  a_dead_acquire: assert property (@(posedge i_clk) disable iff (!i_resetn)
    ((state_ff.st == SBM_SLAVE || state_ff.st == SBM_WAIT) && !i_arb.bus_release_n && !i_arb.bus_grant_n)
      |=> !o_bus_drive_en && !o_sample_ok)
    else $error("no dead cycle when taking the bus");
  a_req_cause: assert property (@(posedge i_clk) disable iff (!i_resetn)
    ($fell(o_bus_request_n)) |-> $past(i_user.work_ready && i_user.resources_ok))
    else $error("request raised without work");
  a_issue_master: assert property (@(posedge i_clk) disable iff (!i_resetn)
    o_issue_ok |-> o_is_master)
    else $error("issue allowed outside master state");
  a_req_hold: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (!o_bus_request_n && i_arb.bus_grant_n && !state_ff.gnt_seen) |=> !o_bus_request_n)
    else $error("request dropped before grant");

endmodule : sbm_arb_handshake
`default_nettype wire

/* File: sbm_agent_model.sv */
// Purpose: external agent end of the mastership handshake
// Assumes: single processor, agent parks its grant
// Notes: release strobe lasts one cycle, a cycle after grant
`timescale 1ns/10ps
`default_nettype none
module sbm_agent_model
  import sbm_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_take,
  input wire logic i_bus_request_n,
  input wire logic i_bus_release_n,
  output var sbm_arb_in_t o_arb
);
  logic gnt_ff;
  logic rel_ff;
  logic own_ff;
  // grant falls at once when the agent wants the bus back
  assign o_arb.bus_grant_n = ~gnt_ff | i_take;
  assign o_arb.bus_release_n = ~rel_ff;
  always @(negedge i_clk) begin
    if (!i_resetn) begin
      gnt_ff <= 1'b0;
      rel_ff <= 1'b0;
      own_ff <= 1'b1;
    end else begin
      // grant stays parked while nobody else asks
      // lone requester: round robin rotation reduces to parking
      if (i_take) gnt_ff <= 1'b0;
      else if (!i_bus_request_n) gnt_ff <= 1'b1;
      rel_ff <= gnt_ff & own_ff & ~rel_ff & ~i_take;
      if (rel_ff) own_ff <= 1'b0;
      else if (!i_bus_release_n) own_ff <= 1'b1;
    end
  end
endmodule : sbm_agent_model
`default_nettype wire

/* File: system_bus_mastership_handshake_bench.sv */
// Purpose: self-checking bench of the processor handshake end
// Assumes: agent model on the far side
// Notes: sampled 1 ns after the falling edge, when all is settled
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin error_cnt++; \
  $display("[FAIL] %s exp %0h got %0h", n, e, s); end end
module system_bus_mastership_handshake_bench;
  import sbm_pkg::*;
  logic i_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic take = 1'b1;
  sbm_user_t usr = '0;
  sbm_arb_in_t arb;
  logic req_n, rel_n, drv, iss, smp, mst;
  int error_cnt = 0;
  int samples_checked = 0;
  sbm_agent_model sbm_agent_model_i (.i_clk(i_clk), .i_resetn(i_resetn), .i_take(take),
    .i_bus_request_n(req_n), .i_bus_release_n(rel_n), .o_arb(arb));
  sbm_arb_handshake sbm_arb_handshake_i (.i_clk(i_clk), .i_resetn(i_resetn), .i_user(usr),
    .i_arb(arb), .o_bus_request_n(req_n), .o_bus_release_n(rel_n), .o_bus_drive_en(drv),
    .o_issue_ok(iss), .o_sample_ok(smp), .o_is_master(mst));
  initial begin
    forever #5 i_clk = ~i_clk;
  end
  task automatic step();
    @(negedge i_clk);
    #1;
  endtask : step
  task automatic t_no_req();
    usr.work_ready = 1'b1;
    repeat (5) begin
      step();
      `CHK("req_no_res", 1'b1, req_n)
    end
    usr = 3'h2;
    repeat (5) begin
      step();
      `CHK("req_no_work", 1'b1, req_n)
    end
    usr.work_ready = 1'b1;
    step();
    step();
    `CHK("req_raised", 1'b0, req_n)
    usr.work_ready = 1'b0;
  endtask : t_no_req
  task automatic t_acquire();
    // need gone, grant withheld: request must stay up
    repeat (3) begin
      step();
      `CHK("req_held", 1'b0, req_n)
    end
    take = 1'b0;
    step();
    step();
    step();
    `CHK("req_late", 1'b0, req_n)
    `CHK("drv_early", 1'b0, drv)
    `CHK("dead_in_smp", 1'b0, smp)
    step();
    `CHK("req_drop", 1'b1, req_n)
    `CHK("drv_on", 1'b1, drv)
    `CHK("smp_on", 1'b1, smp)
    `CHK("master", 1'b1, mst)
    `CHK("issue_ok", 1'b1, iss)
    usr.issue = 1'b1;
    step();
    step();
    usr.issue = 1'b0;
    `CHK("keep_master", 1'b1, mst)
  endtask : t_acquire
  task automatic t_handback(input logic hold);
    int n;
    usr.issue = hold;
    take = 1'b1;
    repeat (2) begin
      step();
      `CHK("rel_early", 1'b1, rel_n)
      `CHK("still_master", 1'b1, mst)
    end
    if (hold) begin
      repeat (4) begin
        step();
        `CHK("rel_postponed", 1'b1, rel_n)
      end
    end
    usr.issue = 1'b0;
    n = 0;
    while (rel_n !== 1'b0 && n < 6) begin
      step();
      n++;
    end
    `CHK("rel_pulse", 1'b0, rel_n)
    step();
    `CHK("rel_one", 1'b1, rel_n)
    `CHK("dead_drv", 1'b0, drv)
    `CHK("dead_smp", 1'b0, smp)
    step();
    step();
    `CHK("slave", 1'b0, mst)
    `CHK("no_issue", 1'b0, iss)
  endtask : t_handback
  task automatic t_mid_reset();
    usr.work_ready = 1'b1;
    step();
    step();
    usr.work_ready = 1'b0;
    t_acquire();
    i_resetn = 1'b0;
    take = 1'b1;
    repeat (2) step();
    `CHK("mid_rst_drv", 1'b0, drv)
    `CHK("mid_rst_mst", 1'b0, mst)
    `CHK("mid_rst_req", 1'b1, req_n)
    `CHK("mid_rst_rel", 1'b1, rel_n)
    `CHK("mid_rst_iss", 1'b0, iss)
    i_resetn = 1'b1;
    step();
    step();
    `CHK("post_rst_mst", 1'b0, mst)
    `CHK("post_rst_req", 1'b1, req_n)
  endtask : t_mid_reset
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish
  // watchdog: the tests need well under 200 cycles
  initial begin
    #20000;
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    repeat (10) @(negedge i_clk);
    i_resetn = 1'b1;
    #1;
    `CHK("rst_req", 1'b1, req_n)
    `CHK("rst_rel", 1'b1, rel_n)
    `CHK("rst_drv", 1'b0, drv)
    `CHK("rst_mst", 1'b0, mst)
    t_no_req();
    t_acquire();
    t_handback(1'b0);
    usr.work_ready = 1'b1;
    step();
    step();
    usr.work_ready = 1'b0;
    t_acquire();
    t_handback(1'b1);
    t_mid_reset();
    tally_and_finish();
  end
endmodule : system_bus_mastership_handshake_bench
`default_nettype wire
